// *** pwmart_ext_model.sv ***
/*
  Far-side model: two capture pulse sources and an external clock
  source that emits bursts of pulses on command.
  Assumes commands arrive synchronous to aclk.
*/
`timescale 1ns/10ps
module pwmart_ext_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] cap_level,
  input wire logic burst_go,
  input wire logic [3:0] burst_len,
  output logic [1:0] capture_input_pin,
  output logic ext_clock_in,
  output logic burst_busy
);
  logic [3:0] left_r;
  logic [1:0] ph_r;

  always_ff @(posedge aclk) begin
    capture_input_pin <= cap_level;
  end

  // Each pulse is two cycles high, two low; the clock rests low between bursts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burst_busy <= 1'b0;
      ext_clock_in <= 1'b0;
      ph_r <= 2'h0;
      left_r <= 4'h0;
    end else if (!burst_busy) begin
      ext_clock_in <= 1'b0;
      ph_r <= 2'h0;
      left_r <= burst_len;
      burst_busy <= burst_go;
    end else begin
      ext_clock_in <= ~ph_r[1];
      ph_r <= ph_r + 2'h1;
      if (ph_r == 2'h3) begin
        left_r <= left_r - 4'h1;
        burst_busy <= (left_r != 4'h1);
      end
    end
  end
endmodule

// *** pwmart_pkg.sv ***
/*
  Package for the PWM auto-reload timer with input capture: register
  offsets, field positions, reset values and carrier structs.
  Assumes a 32-bit AXI4-Lite register bus; each register sits in the low byte of one word.
*/
package pwmart_pkg;
  localparam logic [7:0] PWMART_OFS_CSR = 8'h00;
  localparam logic [7:0] PWMART_OFS_CNT = 8'h04;
  localparam logic [7:0] PWMART_OFS_RLD = 8'h08;
  localparam logic [7:0] PWMART_OFS_PWMC = 8'h0c;
  localparam logic [7:0] PWMART_OFS_DUTY0 = 8'h10;
  localparam logic [7:0] PWMART_OFS_DUTY1 = 8'h14;
  localparam logic [7:0] PWMART_OFS_CCS = 8'h18;
  localparam logic [7:0] PWMART_OFS_CAP0 = 8'h1c;
  localparam logic [7:0] PWMART_OFS_CAP1 = 8'h20;
  localparam logic [7:0] PWMART_OFS_SYS = 8'h24;
  localparam int PWMART_CSR_EXT = 7;
  localparam int PWMART_CSR_PS_LO = 4;
  localparam int PWMART_CSR_RUN = 3;
  localparam int PWMART_CSR_FRL = 2;
  localparam int PWMART_CSR_OIE = 1;
  localparam int PWMART_CSR_OVF = 0;
  localparam int PWMART_PWMC_OE_LO = 4;
  localparam int PWMART_PWMC_POL_LO = 0;
  localparam int PWMART_CCS_EDGE_LO = 4;
  localparam int PWMART_CCS_IE_LO = 2;
  localparam int PWMART_CCS_FLAG_LO = 0;
  localparam int PWMART_SYS_HALT = 0;
  localparam logic [7:0] PWMART_RST_BYTE = 8'h00;
  localparam logic [6:0] PWMART_PS_RST = 7'h00;
  localparam logic [7:0] PWMART_CNT_TOP = 8'hff;
  localparam logic [1:0] PWMART_RESP_OKAY = 2'h0;
  localparam logic [1:0] PWMART_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic ext_clock_select;
    logic [2:0] prescale_select;
    logic counter_run;
    logic overflow_irq_enable;
  } pwmart_ctrl_s;

  typedef struct packed {
    logic [1:0] pwm_enable;
    logic [1:0] pwm_polarity;
  } pwmart_pwmc_s;
endpackage

// *** pwmart_top.sv ***
/*
  PWM auto-reload timer: 7-bit prescaler, 8-bit auto-reload counter,
  two PWM channels and two input-capture channels, AXI4-Lite slave.
  Assumes all inputs synchronous to aclk; ext_clock_in is sampled and
  its rising edge counted, so it must be slower than aclk / 2.
*/
`timescale 1ns/10ps
module pwmart_top
  import pwmart_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clock_in,
  input wire logic [1:0] capture_input_pin,
  output logic [1:0] pwm_output_pin,
  output logic [1:0] pwm_output_oe,
  output logic timer_irq,
  output logic wake_request
);
  pwmart_ctrl_s ctrl_r;
  pwmart_pwmc_s pwmc_r;
  logic overflow_flag_r;
  logic halt_r;
  logic [6:0] presc_r;
  logic [7:0] count_r;
  logic [7:0] reload_value_r;
  logic [7:0] duty_cycle_r [2];
  logic [7:0] compare_shadow_r [2];
  logic [7:0] capture_data_r [2];
  logic [1:0] capture_flag_r;
  logic [1:0] capture_edge_select_r;
  logic [1:0] capture_irq_enable_r;
  logic [1:0] cap_pin_d_r;
  logic [1:0] pwm_level_r;
  logic ext_d_r;
  logic aw_full_r;
  logic w_full_r;
  logic [7:0] aw_addr_r;
  logic [7:0] w_byte_r;
  logic w_lane_r;
  logic input_tick;
  logic presc_tick;
  logic cnt_tick;
  logic overflow;
  logic sw_load;
  logic wr_go;
  logic rd_go;
  logic wr_csr;
  logic wr_cnt;
  logic rd_csr;
  logic [1:0] cap_event;
  logic [1:0] cap_rd;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic wr_hit;
  logic [7:0] tap_mask;

  // Write channel: address and data taken in either order, one at a time
  assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wr_hit = (aw_addr_r <= PWMART_OFS_SYS) && (aw_addr_r[1:0] == 2'h0);
  assign wr_csr = wr_go && w_lane_r && (aw_addr_r == PWMART_OFS_CSR);
  assign wr_cnt = wr_go && w_lane_r && (aw_addr_r == PWMART_OFS_CNT);
  assign rd_csr = rd_go && (s_axi_araddr == PWMART_OFS_CSR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= PWMART_RST_BYTE;
      w_byte_r <= PWMART_RST_BYTE;
      w_lane_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PWMART_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_full_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_full_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        w_byte_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? PWMART_RESP_OKAY : PWMART_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= '0;
      pwmc_r <= '0;
      reload_value_r <= PWMART_RST_BYTE;
      duty_cycle_r[0] <= PWMART_RST_BYTE;
      duty_cycle_r[1] <= PWMART_RST_BYTE;
      capture_edge_select_r <= 2'h0;
      capture_irq_enable_r <= 2'h0;
      halt_r <= 1'b0;
    end else if (wr_go && w_lane_r) begin
      unique case (aw_addr_r)
        PWMART_OFS_CSR: begin
          ctrl_r.ext_clock_select <= w_byte_r[PWMART_CSR_EXT];
          ctrl_r.prescale_select <= w_byte_r[PWMART_CSR_PS_LO +: 3];
          ctrl_r.counter_run <= w_byte_r[PWMART_CSR_RUN];
          ctrl_r.overflow_irq_enable <= w_byte_r[PWMART_CSR_OIE];
        end
        PWMART_OFS_RLD: reload_value_r <= w_byte_r;
        PWMART_OFS_PWMC: begin
          pwmc_r.pwm_enable <= w_byte_r[PWMART_PWMC_OE_LO +: 2];
          pwmc_r.pwm_polarity <= w_byte_r[PWMART_PWMC_POL_LO +: 2];
        end
        PWMART_OFS_DUTY0: duty_cycle_r[0] <= w_byte_r;
        PWMART_OFS_DUTY1: duty_cycle_r[1] <= w_byte_r;
        PWMART_OFS_CCS: begin
          capture_edge_select_r <= w_byte_r[PWMART_CCS_EDGE_LO +: 2];
          capture_irq_enable_r <= w_byte_r[PWMART_CCS_IE_LO +: 2];
        end
        PWMART_OFS_SYS: halt_r <= w_byte_r[PWMART_SYS_HALT];
        default: ;
      endcase
    end
  end

  // Prescaler input: CPU clock every cycle, or a sampled external rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_d_r <= 1'b0;
    end else begin
      ext_d_r <= ext_clock_in;
    end
  end
  assign input_tick = ctrl_r.ext_clock_select ? (ext_clock_in && !ext_d_r) : 1'b1;

  // Tap n ticks when the low n prescaler bits are all ones
  assign tap_mask = 8'((8'h01 << ctrl_r.prescale_select) - 8'h01);
  assign presc_tick = ((presc_r & tap_mask[6:0]) == tap_mask[6:0]);
  assign cnt_tick = ctrl_r.counter_run && input_tick && presc_tick;
  // A software load of the counter wins, so no rollover is seen on that edge
  assign sw_load = (wr_csr && w_byte_r[PWMART_CSR_FRL]) || wr_cnt;
  assign overflow = cnt_tick && (count_r == PWMART_CNT_TOP) && !sw_load;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= PWMART_PS_RST;
    end else if (sw_load) begin
      presc_r <= PWMART_PS_RST;
    end else if (ctrl_r.counter_run && input_tick) begin
      presc_r <= 7'(presc_r + 7'h01);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= PWMART_RST_BYTE;
    end else if (wr_csr && w_byte_r[PWMART_CSR_FRL]) begin
      count_r <= reload_value_r;
    end else if (wr_cnt) begin
      count_r <= w_byte_r;
    end else if (overflow) begin
      count_r <= reload_value_r;
    end else if (cnt_tick) begin
      count_r <= 8'(count_r + 8'h01);
    end
  end

  // Overflow flag: a new overflow wins over the clearing read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag_r <= 1'b0;
    end else if (overflow) begin
      overflow_flag_r <= 1'b1;
    end else if (rd_csr) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // PWM channels, capture channels
  for (genvar i = 0; i < 2; i++) begin : g_ch
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        compare_shadow_r[i] <= PWMART_RST_BYTE;
        pwm_level_r[i] <= 1'b0;
      end else if (overflow) begin
        compare_shadow_r[i] <= duty_cycle_r[i];
        pwm_level_r[i] <= 1'b1;
      end else if (cnt_tick && (count_r == compare_shadow_r[i])) begin
        pwm_level_r[i] <= 1'b0;
      end
    end
    // Polarity is applied combinationally ahead of the output flop
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pwm_output_pin[i] <= 1'b0;
        pwm_output_oe[i] <= 1'b0;
      end else begin
        pwm_output_pin[i] <= pwmc_r.pwm_enable[i] &&
          (pwm_level_r[i] ^ pwmc_r.pwm_polarity[i]);
        pwm_output_oe[i] <= pwmc_r.pwm_enable[i];
      end
    end

    assign cap_event[i] = capture_edge_select_r[i] ?
      (capture_input_pin[i] && !cap_pin_d_r[i]) :
      (!capture_input_pin[i] && cap_pin_d_r[i]);
    assign cap_rd[i] = rd_go &&
      (s_axi_araddr == (i == 0 ? PWMART_OFS_CAP0 : PWMART_OFS_CAP1));

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cap_pin_d_r[i] <= 1'b0;
        capture_flag_r[i] <= 1'b0;
        capture_data_r[i] <= PWMART_RST_BYTE;
      end else begin
        cap_pin_d_r[i] <= capture_input_pin[i];
        if (cap_event[i] && !capture_flag_r[i]) begin
          capture_flag_r[i] <= 1'b1;
          capture_data_r[i] <= count_r;
        end else if (cap_rd[i]) begin
          capture_flag_r[i] <= 1'b0;
        end
      end
    end

    chk_cap_latch: assert property (@(posedge aclk) disable iff (!aresetn)
      cap_event[i] && !capture_flag_r[i] |=> capture_flag_r[i] &&
      capture_data_r[i] == $past(count_r)) else $error("capture not latched");
    chk_cap_inhibit: assert property (@(posedge aclk) disable iff (!aresetn)
      capture_flag_r[i] && !cap_rd[i] |=> $stable(capture_data_r[i]) && capture_flag_r[i])
      else $error("capture data changed while flag set");
    chk_pwm_pol: assert property (@(posedge aclk) disable iff (!aresetn)
      pwmc_r.pwm_enable[i] |=> pwm_output_pin[i] ==
      ($past(pwm_level_r[i]) ^ $past(pwmc_r.pwm_polarity[i])))
      else $error("pwm level wrong for polarity");
  end

  // Interrupt and wake outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      timer_irq <= |(capture_flag_r & capture_irq_enable_r) ||
        (overflow_flag_r && ctrl_r.overflow_irq_enable);
      wake_request <= halt_r && (|(cap_event & capture_irq_enable_r) ||
        |(capture_flag_r & capture_irq_enable_r));
    end
  end

  // Read channel
  always_comb begin
    rd_byte = PWMART_RST_BYTE;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      PWMART_OFS_CSR: rd_byte = {ctrl_r.ext_clock_select, ctrl_r.prescale_select,
        ctrl_r.counter_run, 1'b0, ctrl_r.overflow_irq_enable, overflow_flag_r};
      PWMART_OFS_CNT: rd_byte = count_r;
      PWMART_OFS_RLD: rd_byte = reload_value_r;
      PWMART_OFS_PWMC: rd_byte = {2'h0, pwmc_r.pwm_enable, 2'h0, pwmc_r.pwm_polarity};
      PWMART_OFS_DUTY0: rd_byte = duty_cycle_r[0];
      PWMART_OFS_DUTY1: rd_byte = duty_cycle_r[1];
      PWMART_OFS_CCS: rd_byte = {2'h0, capture_edge_select_r, capture_irq_enable_r,
        capture_flag_r};
      PWMART_OFS_CAP0: rd_byte = capture_data_r[0];
      PWMART_OFS_CAP1: rd_byte = capture_data_r[1];
      PWMART_OFS_SYS: rd_byte = {7'h00, halt_r};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PWMART_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_hit ? PWMART_RESP_OKAY : PWMART_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  chk_ovf_set: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow |=> overflow_flag_r && count_r == $past(reload_value_r))
    else $error("overflow did not reload or flag");
  chk_ovf_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_csr && !overflow |=> !overflow_flag_r) else $error("status read kept flag");
  chk_run_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_r.counter_run && !wr_csr && !wr_cnt |=> $stable(count_r) && $stable(presc_r))
    else $error("counter moved while stopped");
  chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    |(capture_flag_r & capture_irq_enable_r) |=> timer_irq)
    else $error("capture irq not asserted");
  chk_frl_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_csr && w_byte_r[PWMART_CSR_FRL] |=> count_r == $past(reload_value_r) && presc_r == 7'h00)
    else $error("force reload failed");
  chk_cnt_step: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_tick && !overflow && !wr_csr && !wr_cnt |=> count_r == 8'($past(count_r) + 8'h01))
    else $error("counter did not step");
endmodule

// *** pwmart_top_bench.sv ***
/*
  Self-checking bench for the PWM auto-reload timer: AXI4-Lite master
  tasks and directed sequences. Assumes the far-side model beside it.
*/
`timescale 1ns/10ps
module pwmart_top_bench;
  import pwmart_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, capture_input_pin, pwm_output_pin, pwm_output_oe;
  logic ext_clock_in, timer_irq, wake_request, burst_busy;
  logic burst_go = 1'b0;
  logic [1:0] cap_level = 2'h2;
  logic [3:0] burst_len = 4'h5;
  logic [31:0] dlt;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int t_b, t0;

  pwmart_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ext_clock_in, .capture_input_pin, .pwm_output_pin,
    .pwm_output_oe, .timer_irq, .wake_request);

  pwmart_ext_model ext_u (.aclk, .aresetn, .cap_level, .burst_go, .burst_len,
    .capture_input_pin, .ext_clock_in, .burst_busy);

  always #20 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  task automatic close_out;
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic [1:0] er = PWMART_RESP_OKAY);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 100) begin
        n_errors++;
        close_out;
      end
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    t_b = cyc;
    chk(s_axi_bresp, er);
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er = PWMART_RESP_OKAY);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 100) begin
        n_errors++;
        close_out;
      end
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
    @(posedge aclk);
  endtask

  // Counts high cycles of both PWM pins over two 16-cycle periods
  task automatic pwm_cnt(input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] h0, h1;
    h0 = 8'h00;
    h1 = 8'h00;
    repeat (32) begin
      @(posedge aclk);
      h0 += pwm_output_pin[0];
      h1 += pwm_output_pin[1];
    end
    chk(h0, e0);
    chk(h1, e1);
  endtask

  // One capture edge pair on channel 0: low, then high
  task automatic pulse0;
    cap_level <= {cap_level[1], 1'b0};
    repeat (2) @(posedge aclk);
    cap_level <= {cap_level[1], 1'b1};
    repeat (4) @(posedge aclk);
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0);
    rd(8'h30, 32'h0, PWMART_RESP_SLVERR);
    wr(8'h30, 8'h55, PWMART_RESP_SLVERR);
    s_axi_wstrb <= 4'h0;
    wr(PWMART_OFS_RLD, 8'h55);
    s_axi_wstrb <= 4'h1;
    rd(PWMART_OFS_RLD, 32'h0);
    for (int p = 0; p < 8; p++) begin
      wr(PWMART_OFS_CNT, 8'h00);
      wr(PWMART_OFS_CSR, {1'b0, 3'(p), 4'h8});
      t0 = t_b;
      repeat ((7 << p) / 2) @(posedge aclk);
      wr(PWMART_OFS_CSR, 8'h00);
      dlt = ((t_b - t0) >> p) & 32'hff;
      rd(PWMART_OFS_CNT, dlt);
      repeat (20) @(posedge aclk);
      rd(PWMART_OFS_CNT, dlt);
    end
    wr(PWMART_OFS_CNT, 8'h00);
    wr(PWMART_OFS_CSR, 8'h88);
    burst_go <= 1'b1;
    @(posedge aclk);
    burst_go <= 1'b0;
    repeat (2) @(posedge aclk);
    for (int i = 0; burst_busy; i++) begin
      if (i > 100) begin
        n_errors++;
        close_out;
      end
      @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
    wr(PWMART_OFS_CSR, 8'h80);
    rd(PWMART_OFS_CNT, 32'h5);
    wr(PWMART_OFS_RLD, 8'hf0);
    wr(PWMART_OFS_DUTY0, 8'hf4);
    wr(PWMART_OFS_DUTY1, 8'hf8);
    wr(PWMART_OFS_PWMC, 8'h32);
    wr(PWMART_OFS_CSR, 8'h0c);
    repeat (40) @(posedge aclk);
    pwm_cnt(8'd10, 8'd14);
    chk(pwm_output_oe, 2'h3);
    chk(timer_irq, 1'b0);
    wr(PWMART_OFS_PWMC, 8'h33);
    repeat (3) @(posedge aclk);
    pwm_cnt(8'd22, 8'd14);
    wr(PWMART_OFS_DUTY0, 8'hf7);
    repeat (40) @(posedge aclk);
    pwm_cnt(8'd16, 8'd14);
    wr(PWMART_OFS_PWMC, 8'h23);
    repeat (3) @(posedge aclk);
    chk(pwm_output_oe, 2'h2);
    pwm_cnt(8'd0, 8'd14);
    wr(PWMART_OFS_CSR, 8'h0a);
    repeat (3) @(posedge aclk);
    chk(timer_irq, 1'b1);
    wr(PWMART_OFS_CSR, 8'h02);
    rd(PWMART_OFS_CSR, 32'h03);
    rd(PWMART_OFS_CSR, 32'h02);
    repeat (2) @(posedge aclk);
    chk(timer_irq, 1'b0);
    wr(PWMART_OFS_RLD, 8'h77);
    wr(PWMART_OFS_CSR, 8'h06);
    rd(PWMART_OFS_CSR, 32'h02);
    rd(PWMART_OFS_CNT, 32'h77);
    wr(PWMART_OFS_CNT, 8'h3c);
    wr(PWMART_OFS_CCS, 8'h1c);
    pulse0;
    chk(timer_irq, 1'b1);
    rd(PWMART_OFS_CCS, 32'h1d);
    wr(PWMART_OFS_CNT, 8'h44);
    pulse0;
    rd(PWMART_OFS_CAP0, 32'h3c);
    rd(PWMART_OFS_CCS, 32'h1c);
    chk(timer_irq, 1'b0);
    cap_level <= 2'h1;
    repeat (4) @(posedge aclk);
    rd(PWMART_OFS_CAP1, 32'h44);
    cap_level <= 2'h3;
    repeat (4) @(posedge aclk);
    rd(PWMART_OFS_CCS, 32'h1c);
    wr(PWMART_OFS_CCS, 8'h10);
    pulse0;
    chk(timer_irq, 1'b0);
    rd(PWMART_OFS_CCS, 32'h11);
    rd(PWMART_OFS_CAP0, 32'h44);
    wr(PWMART_OFS_SYS, 8'h01);
    wr(PWMART_OFS_CCS, 8'h14);
    pulse0;
    chk(wake_request, 1'b1);
    chk(timer_irq, 1'b1);
    rd(PWMART_OFS_CAP0, 32'h44);
    wr(PWMART_OFS_SYS, 8'h00);
    repeat (2) @(posedge aclk);
    chk(wake_request, 1'b0);
    wr(PWMART_OFS_CCS, 8'hff);
    rd(PWMART_OFS_CCS, 32'h3c);
    close_out;
  end
endmodule
